// *** src/acq_setup_consts.svh ***
// What this block does
// R1: Device is a bus target only; every register access is a full 32-bit word.
// R2: Nine word registers at offsets 0x00 to 0x20; only 0x18 reads back status.
// R3: Offset 0x00 bits 3..0 enable lanes a..d; upper bits ignored.
// R4: Host writes only lane patterns 0000, 0001, 0011 or 1111.
// R5: Sample clock is source clock divided by 16-bit divisor at offset 0x04.
// R6: Divisor bit 0 is forced to zero; host never programs below two.
// R7: Offset 0x08 bits 2..0 select software, post, pre, delay or middle trigger.
// R8: Any other trigger mode code blocks all sample acquisition; here it clears acquireAllowed only, the sample clock keeps running.
// R9: Sample clock never exceeds half the selected source clock frequency.
// R10: Sampling starts only after acquisition enable is written one; zero disables.
// R11: Reset clears lane enables, divisor and trigger mode to zero.
`ifndef ACQ_SETUP_CONSTS_SVH
`define ACQ_SETUP_CONSTS_SVH
`define ACQ_OFS_LANE      6'h00
`define ACQ_OFS_DIVISOR   6'h04
`define ACQ_OFS_TRIGMODE  6'h08
`define ACQ_OFS_THRESH    6'h0C
`define ACQ_OFS_ORIGIN    6'h10
`define ACQ_OFS_AFTERCNT  6'h14
`define ACQ_OFS_BUFCS     6'h18
`define ACQ_OFS_ACQUISITION_ENABLE_BIT     6'h1C
`define ACQ_OFS_CLKSEL    6'h20
`define ACQ_MAX_MODE      3'h4
`define ACQ_MIN_DIVISOR   16'h0002
`define ACQ_ZERO16        16'h0000
`endif

// *** src/acq_setup_pkg.sv ***
package acq_setup_pkg;
  typedef enum logic [2:0] {
    ModeSoftware, ModePost, ModePre, ModeDelay, ModeMiddle
  } acq_trig_mode_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } acq_bus_req_type;

  typedef struct packed {
    logic [3:0]  laneEnable;
    logic [15:0] sampleDivisor;
    logic [2:0]  triggerModeCode;
    logic        acquisitionEnableBit;
    logic [15:0] divCount;
    logic        sampleClk;
    logic [31:0] rdata;
  } acq_state_type;
endpackage

// *** src/acq_setup_regs.sv ***
`include "acq_setup_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module acq_setup_regs
  import acq_setup_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire acq_bus_req_type busReq,
  input  wire logic [31:0]     bufferStatus,
  input  wire logic            sourceClkTick,
  output logic [31:0]          readData,
  output logic                 laneAEnable,
  output logic                 laneBEnable,
  output logic                 laneCEnable,
  output logic                 laneDEnable,
  output logic [2:0]           triggerModeCode,
  output logic                 sampleClk,
  output logic                 acquireAllowed
);
  acq_state_type stateQ;
  acq_state_type stateD;
  logic          modeLegal;
  logic [15:0]   halfDiv;
  logic          dividerRun;

  function automatic logic hitOffset(input acq_bus_req_type req, input logic [5:0] ofs);
    hitOffset = req.write && (req.addr == ofs);
  endfunction

  // Codes above middle trigger are illegal and must block acquisition.
  assign modeLegal = (stateQ.triggerModeCode <= `ACQ_MAX_MODE); // [R7] [R8]
  assign halfDiv   = {1'b0, stateQ.sampleDivisor[15:1]};
  // The divider only runs with acquisition on and a legal divisor; the checks below lean on this.
  assign dividerRun = stateQ.acquisitionEnableBit && (stateQ.sampleDivisor >= `ACQ_MIN_DIVISOR);

  always_comb
  begin
    stateD = stateQ;
    if (hitOffset(busReq, `ACQ_OFS_LANE))
      stateD.laneEnable = busReq.wdata[3:0]; // [R1] [R3]
    if (hitOffset(busReq, `ACQ_OFS_DIVISOR))
      stateD.sampleDivisor = {busReq.wdata[15:1], 1'b0}; // [R5] [R6]
    if (hitOffset(busReq, `ACQ_OFS_TRIGMODE))
      stateD.triggerModeCode = busReq.wdata[2:0]; // [R7]
    if (hitOffset(busReq, `ACQ_OFS_ACQUISITION_ENABLE_BIT))
      stateD.acquisitionEnableBit = busReq.wdata[0]; // [R10]
    // Only the buffer status word reads back; the rest are write only.
    if (busReq.read && busReq.addr == `ACQ_OFS_BUFCS)
      stateD.rdata = bufferStatus; // [R2]
    else if (busReq.read)
      stateD.rdata = 32'h0000_0000;
    // The divider toggles every half period, so even ratios of two or more
    // never exceed half the source rate; a zero divisor holds the clock low.
    if (stateQ.sampleDivisor < `ACQ_MIN_DIVISOR || !stateQ.acquisitionEnableBit)
    begin
      stateD.divCount  = `ACQ_ZERO16;
      stateD.sampleClk = 1'b0;
    end
    else if (sourceClkTick)
    begin
      if (stateQ.divCount + 16'h0001 >= halfDiv) // [R5] [R9]
      begin
        stateD.divCount  = `ACQ_ZERO16;
        stateD.sampleClk = !stateQ.sampleClk;
      end
      else
        stateD.divCount = stateQ.divCount + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      stateQ <= '0; // [R11]
    else
      stateQ <= stateD;
  end

  assign readData        = stateQ.rdata;
  assign laneAEnable     = stateQ.laneEnable[0];
  assign laneBEnable     = stateQ.laneEnable[1];
  assign laneCEnable     = stateQ.laneEnable[2];
  assign laneDEnable     = stateQ.laneEnable[3];
  assign triggerModeCode = stateQ.triggerModeCode;
  assign sampleClk       = stateQ.sampleClk;
  assign acquireAllowed  = stateQ.acquisitionEnableBit && modeLegal; // [R8] [R10]

  property p_lane_write;
    @(posedge clk) disable iff (reset)
      (busReq.write && busReq.addr == `ACQ_OFS_LANE) |=> (stateQ.laneEnable == $past(busReq.wdata[3:0]));
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("Lane enables not loaded."); // [R3]

  property p_div_even;
    @(posedge clk) disable iff (reset) stateQ.sampleDivisor[0] == 1'b0;
  endproperty
  a_div_even: assert property (p_div_even) else $error("Divisor bit zero set."); // [R6]

  property p_div_write;
    @(posedge clk) disable iff (reset)
      (busReq.write && busReq.addr == `ACQ_OFS_DIVISOR) |=> (stateQ.sampleDivisor[15:1] == $past(busReq.wdata[15:1]));
  endproperty
  a_div_write: assert property (p_div_write) else $error("Divisor not loaded."); // [R5]

  property p_mode_write;
    @(posedge clk) disable iff (reset)
      (busReq.write && busReq.addr == `ACQ_OFS_TRIGMODE) |=> (triggerModeCode == $past(busReq.wdata[2:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Trigger mode not loaded."); // [R7]

  property p_illegal_block;
    @(posedge clk) disable iff (reset) (triggerModeCode > `ACQ_MAX_MODE) |-> !acquireAllowed;
  endproperty
  a_illegal_block: assert property (p_illegal_block) else $error("Acquire with illegal mode."); // [R8]

  // A disable is two steps: the gate closes first, the divided clock falls one cycle later.
  sequence s_disable_write;
    busReq.write && (busReq.addr == `ACQ_OFS_ACQUISITION_ENABLE_BIT) && !busReq.wdata[0];
  endsequence

  sequence s_gate_closed;
    !acquireAllowed ##1 !sampleClk;
  endsequence

  property p_enable_gate;
    @(posedge clk) disable iff (reset)
      s_disable_write |=> s_gate_closed;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("Acquire after disable."); // [R10]

  // A rising sample clock must come from a source tick, so it never outruns half the source.
  property p_half_rate;
    @(posedge clk) disable iff (reset)
      (sampleClk && !$past(sampleClk)) |-> $past(sourceClkTick);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("Sample clock too fast."); // [R9]

  property p_idle_no_toggle;
    @(posedge clk) disable iff (reset)
      (dividerRun && !sourceClkTick) |=> $stable(sampleClk);
  endproperty
  a_idle_no_toggle: assert property (p_idle_no_toggle) else $error("Sample clock moved without tick."); // [R9]

  sequence s_setup_kept;
    $stable(stateQ.laneEnable) && $stable(stateQ.sampleDivisor) && $stable(stateQ.triggerModeCode)
      && $stable(stateQ.acquisitionEnableBit);
  endsequence

  // Registers kept outside this block must not disturb the setup held here.
  sequence s_refused_write;
    hitOffset(busReq, `ACQ_OFS_THRESH) || hitOffset(busReq, `ACQ_OFS_ORIGIN)
      || hitOffset(busReq, `ACQ_OFS_AFTERCNT) || hitOffset(busReq, `ACQ_OFS_BUFCS)
      || hitOffset(busReq, `ACQ_OFS_CLKSEL);
  endsequence

  property p_refused_write;
    @(posedge clk) disable iff (reset)
      s_refused_write |=> s_setup_kept;
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("Foreign write changed setup."); // [R2]

  property p_read_no_effect;
    @(posedge clk) disable iff (reset)
      (busReq.read && !busReq.write) |=> s_setup_kept;
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("Read changed setup."); // [R2]

  property p_lane_hold;
    @(posedge clk) disable iff (reset)
      !hitOffset(busReq, `ACQ_OFS_LANE) |=> $stable(stateQ.laneEnable);
  endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("Lane enables changed unasked."); // [R3]

  property p_div_hold;
    @(posedge clk) disable iff (reset)
      !hitOffset(busReq, `ACQ_OFS_DIVISOR) |=> $stable(stateQ.sampleDivisor);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("Divisor changed unasked."); // [R5]

  property p_mode_hold;
    @(posedge clk) disable iff (reset)
      !hitOffset(busReq, `ACQ_OFS_TRIGMODE) |=> $stable(triggerModeCode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("Trigger mode changed unasked."); // [R7]

  property p_acquisition_enable_bit_write;
    @(posedge clk) disable iff (reset)
      hitOffset(busReq, `ACQ_OFS_ACQUISITION_ENABLE_BIT) |=> (stateQ.acquisitionEnableBit == $past(busReq.wdata[0]));
  endproperty
  a_acquisition_enable_bit_write: assert property (p_acquisition_enable_bit_write) else $error("Acquisition enable not loaded."); // [R10]

  property p_acquisition_enable_bit_hold;
    @(posedge clk) disable iff (reset)
      !hitOffset(busReq, `ACQ_OFS_ACQUISITION_ENABLE_BIT) |=> $stable(stateQ.acquisitionEnableBit);
  endproperty
  a_acquisition_enable_bit_hold: assert property (p_acquisition_enable_bit_hold) else $error("Acquisition enable changed unasked."); // [R10]

  property p_legal_allow;
    @(posedge clk) disable iff (reset)
      (stateQ.acquisitionEnableBit && (triggerModeCode <= `ACQ_MAX_MODE)) |-> acquireAllowed;
  endproperty
  a_legal_allow: assert property (p_legal_allow) else $error("Legal mode blocked."); // [R8]

  property p_off_blocks;
    @(posedge clk) disable iff (reset)
      !stateQ.acquisitionEnableBit |-> !acquireAllowed;
  endproperty
  a_off_blocks: assert property (p_off_blocks) else $error("Acquire while disabled."); // [R10]

  property p_clk_low_disabled;
    @(posedge clk) disable iff (reset)
      !stateQ.acquisitionEnableBit |=> (!sampleClk && (stateQ.divCount == `ACQ_ZERO16));
  endproperty
  a_clk_low_disabled: assert property (p_clk_low_disabled) else $error("Divider runs while disabled."); // [R10]

  property p_clk_low_small_div;
    @(posedge clk) disable iff (reset)
      (stateQ.sampleDivisor < `ACQ_MIN_DIVISOR) |=> (!sampleClk && (stateQ.divCount == `ACQ_ZERO16));
  endproperty
  a_clk_low_small_div: assert property (p_clk_low_small_div) else $error("Divider runs below minimum."); // [R6]

  // Enabling starts from a low clock, so the first sample edge is always a clean rise.
  property p_enable_quiet;
    @(posedge clk) disable iff (reset)
      $rose(stateQ.acquisitionEnableBit) |-> !sampleClk;
  endproperty
  a_enable_quiet: assert property (p_enable_quiet) else $error("Sample clock high at enable."); // [R10]

  property p_rdata_hold;
    @(posedge clk) disable iff (reset)
      !busReq.read |=> $stable(readData);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read data changed without read."); // [R2]

  property p_status_read;
    @(posedge clk) disable iff (reset)
      (busReq.read && busReq.addr == `ACQ_OFS_BUFCS) |=> (readData == $past(bufferStatus));
  endproperty
  a_status_read: assert property (p_status_read) else $error("Status not returned."); // [R2]

  property p_wo_read;
    @(posedge clk) disable iff (reset)
      (busReq.read && busReq.addr != `ACQ_OFS_BUFCS) |=> (readData == 32'h0000_0000);
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("Write-only register read nonzero."); // [R2] [R1]
endmodule // acq_setup_regs
`default_nettype wire

// *** verification/acq_bus_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module acq_bus_host
  import acq_setup_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] readData,
  output var acq_bus_req_type busReq
);
  initial busReq = '0;
  // Whole words only; released lines show inverted values so stale data cannot pass.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk);
    busReq = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    busReq = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(negedge clk);
    busReq = '{1'b0, 1'b1, a, 32'h0};
    @(negedge clk);
    busReq = '{1'b0, 1'b0, ~a, 32'hFFFFFFFF};
    d = readData;
  endtask
endmodule // acq_bus_host
`default_nettype wire

// *** verification/acq_setup_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module acq_setup_regs_tb
  import acq_setup_pkg::*;
;
  logic            clk = 1'b0, reset = 1'b1, sourceClkTick = 1'b0, tickOn = 1'b0, sampleClk, acquireAllowed;
  logic [31:0]     bufferStatus = 32'hA5C30F21, readData, rv;
  logic [3:0]      lanes;
  logic [2:0]      triggerModeCode;
  acq_bus_req_type busReq;
  int              n_mismatch = 0, checks_done = 0;
  acq_bus_host host_u (.clk(clk), .readData(readData), .busReq(busReq));
  acq_setup_regs dut_u (.clk(clk), .reset(reset), .busReq(busReq), .bufferStatus(bufferStatus),
    .sourceClkTick(sourceClkTick), .readData(readData), .laneAEnable(lanes[0]), .laneBEnable(lanes[1]),
    .laneCEnable(lanes[2]), .laneDEnable(lanes[3]), .triggerModeCode(triggerModeCode),
    .sampleClk(sampleClk), .acquireAllowed(acquireAllowed));
  initial forever #12.5 clk = ~clk;
  // Ticks come every other cycle, so one sample period is twice the divisor in cycles.
  always @(negedge clk) sourceClkTick <= tickOn & ~sourceClkTick;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic t_reset;
    reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    chk("reset", {23'h0, lanes, triggerModeCode, sampleClk, acquireAllowed}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_lanes;
    logic [3:0] pat [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    foreach (pat[i])
    begin
      host_u.wr(6'h00, {28'hFFFFFFF, pat[i]});
      chk("lanes", {28'h0, lanes}, {28'h0, pat[i]});
    end
    host_u.rd(6'h00, rv);
    chk("wo read", rv, 32'h0);
    host_u.rd(6'h18, rv);
    chk("status", rv, bufferStatus);
    $display("lane test done");
  endtask
  task automatic t_mode;
    host_u.wr(6'h1C, 32'hFFFFFFFF);
    for (int m = 7; m >= 0; m--)
    begin
      host_u.wr(6'h08, {29'h1FFFFFFF, 3'(m)});
      chk("mode", {29'h0, triggerModeCode}, 32'(m));
      chk("allowed", {31'h0, acquireAllowed}, {31'h0, m < 5});
    end
    host_u.wr(6'h1C, 32'hFFFFFFFE);
    chk("disabled", {31'h0, acquireAllowed}, 32'h0);
    $display("mode test done");
  endtask
  task automatic rise(output int c);
    // Counts from the last rise through a full high and low half to the next rise.
    c = 0;
    while (sampleClk !== 1'b0 && c < 600)
    begin
      @(negedge clk);
      c++;
    end
    while (sampleClk !== 1'b1 && c < 600)
    begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic t_div(input logic [31:0] w, input int exp);
    int c;
    host_u.wr(6'h04, w);
    host_u.wr(6'h1C, 32'h1);
    tickOn = 1'b1;
    rise(c);
    rise(c);
    chk("period", 32'(c), 32'(2 * exp));
    tickOn = 1'b0;
    $display("divider test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    t_reset;
    t_lanes;
    t_reset;
    t_mode;
    t_div(32'hFFFF0007, 6);
    t_div(32'h3, 2);
    tally_and_finish;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // acq_setup_regs_tb
`default_nettype wire
